// ===== core/nand_host_seq.sv
/* NAND host sequencer: one command frame per request on the strobed pins, none for a refused unchecked erase.
   Assumes a pulled-up busy line and dq resolved from dq_oe outside. */
`timescale 1ns/100ps
`default_nettype none

module nand_host_seq
    import nand_host_pkg::*;
#(
    parameter int POR_CYC = POR_CYC_DEF,
    parameter int BUSY_MAX_CYC = BUSY_MAX_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire req_t req,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output resp_t resp,
    output logic resp_valid,
    input wire logic write_allow,
    output pins_t pins,
    input wire logic [7:0] dq_in,
    input wire logic rb_n_in
);
    initial begin
        if (POR_CYC < 1 || POR_CYC >= (1 << CNT_W) ||
            BUSY_MAX_CYC < 1 || BUSY_MAX_CYC >= (1 << CNT_W)) begin
            $error("wait counts too large");
        end
    end

    // ==========================================================
    // Pin synchronisers
    logic [7:0] dq_meta_ff, dq_sync_ff;
    logic rb_meta_ff, rb_sync_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_meta_ff <= 8'h00;
            dq_sync_ff <= 8'h00;
            rb_meta_ff <= 1'b0;
            rb_sync_ff <= 1'b0;
        end else begin
            dq_meta_ff <= dq_in;
            dq_sync_ff <= dq_meta_ff;
            rb_meta_ff <= rb_n_in;
            rb_sync_ff <= rb_meta_ff;
        end
    end

    // ==========================================================
    // Sequencer state
    state_t state_ff, nxt_state;
    req_t req_ff, nxt_req;
    pins_t pins_ff, nxt_pins;
    resp_t resp_ff, nxt_resp;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [15:0] left_ff, nxt_left;
    logic [2:0] aidx_ff, nxt_aidx;
    logic stat_ff, nxt_stat;
    logic req_ready_ff, nxt_req_ready;
    logic wr_ready_ff, nxt_wr_ready;
    logic resp_valid_ff, nxt_resp_valid;
    logic push;
    logic [7:0] push_data;

    logic [7:0] head_ff, nxt_head, tail_ff, nxt_tail;
    logic [1:0] count_ff, nxt_count;
    logic rd_valid_ff, nxt_rd_valid;
    logic pop;

    function automatic state_t after_data(input req_t r);
        if (r.has_cmd2) begin
            after_data = S_CMD2;
        end else if (r.wait_busy) begin
            after_data = S_WB;
        end else if (r.n_rdata != 16'h0000) begin
            after_data = S_WHR;
        end else begin
            after_data = S_DONE;
        end
    endfunction

    always_comb begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_pins = pins_ff;
        nxt_resp = resp_ff;
        nxt_cnt = cnt_ff + 1'b1;
        nxt_left = left_ff;
        nxt_aidx = aidx_ff;
        nxt_stat = stat_ff;
        nxt_wr_ready = 1'b0;
        nxt_resp_valid = 1'b0;
        push = 1'b0;
        push_data = dq_sync_ff;
        if (state_ff != S_POR) begin
            nxt_pins.wp_n = write_allow;
        end
        unique case (state_ff)
            S_POR: begin
                nxt_pins.wp_n = 1'b0;
                if (rb_sync_ff || cnt_ff == CNT_W'(POR_CYC - 1)) begin
                    nxt_state = S_IDLE;
                end
            end
            S_IDLE: begin
                nxt_cnt = '0;
                if (req_valid && req_ready_ff) begin
                    nxt_req = req;
                    nxt_aidx = 3'd0;
                    nxt_stat = 1'b0;
                    nxt_resp = '0;
                    if (req.cmd1 == OPC_ERASE && !req.marker_checked) begin
                        nxt_resp.refused = 1'b1;
                        nxt_resp_valid = 1'b1;
                        nxt_state = S_DONE;
                    end else begin
                        nxt_pins.ce_n = 1'b0;
                        if (req.cmd1 == OPC_RESET || req.cmd1 == OPC_STATUS ||
                            req.cmd1 == OPC_STATUS_ENH || rb_sync_ff) begin
                            nxt_state = S_CMD1;
                        end else begin
                            nxt_state = S_WAIT_RDY;
                        end
                    end
                end
            end
            S_WAIT_RDY: begin
                nxt_cnt = '0;
                if (rb_sync_ff) begin
                    nxt_state = S_CMD1;
                end
            end
            S_CMD1, S_ADDR, S_CMD2, S_STAT_CMD, S_WDATA: begin
                if (cnt_ff == '0) begin
                    nxt_pins.cle = (state_ff != S_ADDR && state_ff != S_WDATA);
                    nxt_pins.ale = (state_ff == S_ADDR);
                    nxt_pins.dq_oe = 1'b1;
                    nxt_pins.we_n = 1'b0;
                    unique case (state_ff)
                        S_CMD1: nxt_pins.dq_out = req_ff.cmd1;
                        S_CMD2: nxt_pins.dq_out = req_ff.cmd2;
                        S_STAT_CMD: nxt_pins.dq_out = OPC_STATUS;
                        S_ADDR: nxt_pins.dq_out = req_ff.addr[aidx_ff*8 +: 8];
                        default: nxt_pins.dq_out = wr_data;
                    endcase
                    if (state_ff == S_WDATA && !(wr_valid && wr_ready_ff)) begin
                        nxt_pins.we_n = 1'b1;
                        nxt_pins.dq_oe = 1'b0;
                        nxt_cnt = '0;
                        nxt_wr_ready = 1'b1;
                    end
                end else if (cnt_ff == CNT_W'(WE_LOW_CYC)) begin
                    nxt_pins.we_n = 1'b1;
                end else if (cnt_ff == CNT_W'(WE_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_pins.cle = 1'b0;
                    nxt_pins.ale = 1'b0;
                    nxt_pins.dq_oe = 1'b0;
                    unique case (state_ff)
                        S_CMD1: begin
                            if (req_ff.n_addr != 3'd0) begin
                                nxt_state = S_ADDR;
                            end else if (req_ff.n_wdata != 16'h0000) begin
                                nxt_state = S_ADL;
                            end else begin
                                nxt_state = after_data(req_ff);
                            end
                        end
                        S_ADDR: begin
                            nxt_aidx = aidx_ff + 3'd1;
                            if (aidx_ff == req_ff.n_addr - 3'd1) begin
                                nxt_state = (req_ff.n_wdata != 16'h0000) ? S_ADL :
                                    after_data(req_ff);
                            end
                        end
                        S_WDATA: begin
                            nxt_left = left_ff - 16'd1;
                            if (left_ff == 16'd1) begin
                                nxt_state = after_data(req_ff);
                            end else begin
                                nxt_wr_ready = 1'b1;
                            end
                        end
                        S_CMD2: begin
                            nxt_state = req_ff.wait_busy ? S_WB :
                                (req_ff.n_rdata != 16'h0000) ? S_WHR : S_DONE;
                        end
                        default: begin
                            nxt_stat = 1'b1;
                            nxt_state = S_WHR;
                        end
                    endcase
                    if (nxt_state == S_WHR) begin
                        nxt_left = nxt_stat ? 16'd1 : req_ff.n_rdata;
                    end
                    if (nxt_state == S_DONE) begin
                        nxt_resp_valid = 1'b1;
                    end
                end
            end
            S_ADL: begin
                nxt_left = req_ff.n_wdata;
                if (cnt_ff == CNT_W'(ADL_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_wr_ready = 1'b1;
                    nxt_state = S_WDATA;
                end
            end
            S_WB: begin
                if (cnt_ff == CNT_W'(WB_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_state = S_BUSY;
                end
            end
            S_BUSY: begin
                if (rb_sync_ff) begin
                    nxt_cnt = '0;
                    nxt_left = req_ff.n_rdata;
                    if (req_ff.auto_status) begin
                        nxt_state = S_STAT_CMD;
                    end else if (req_ff.n_rdata != 16'h0000) begin
                        nxt_state = S_WHR;
                    end else begin
                        nxt_state = S_DONE;
                        nxt_resp_valid = 1'b1;
                    end
                end else if (cnt_ff == CNT_W'(BUSY_MAX_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_resp.timeout = 1'b1;
                    nxt_resp_valid = 1'b1;
                    nxt_state = S_DONE;
                end
            end
            S_WHR: begin
                if (cnt_ff == CNT_W'(WHR_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_state = S_RDATA;
                end
            end
            S_RDATA: begin
                if (cnt_ff == '0) begin
                    // read strobe only with buffer room, or for a status byte
                    if (count_ff == 2'd2 && !stat_ff) begin
                        nxt_cnt = '0;
                    end else begin
                        nxt_pins.read_strobe_n = 1'b0;
                    end
                end else if (cnt_ff == CNT_W'(RE_SAMPLE_CYC)) begin
                    nxt_pins.read_strobe_n = 1'b1;
                    if (stat_ff) begin
                        nxt_resp.status = dq_sync_ff;
                    end else begin
                        push = 1'b1;
                    end
                end else if (cnt_ff == CNT_W'(RE_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_left = left_ff - 16'd1;
                    if (left_ff == 16'd1) begin
                        nxt_state = S_DONE;
                        nxt_resp_valid = 1'b1;
                    end
                end
            end
            S_DONE: begin
                nxt_pins.ce_n = 1'b1;
                nxt_pins.dq_oe = 1'b0;
                if (cnt_ff == CNT_W'(RHW_CYC - 1)) begin
                    nxt_cnt = '0;
                    nxt_state = S_IDLE;
                end
            end
        endcase
        nxt_req_ready = (nxt_state == S_IDLE);
    end

    // Two-entry read buffer
    always_comb begin
        pop = rd_valid_ff && rd_ready;
        nxt_head = head_ff;
        nxt_tail = tail_ff;
        nxt_count = count_ff;
        if (push && pop) begin
            if (count_ff == 2'd1) begin
                nxt_head = push_data;
            end else begin
                nxt_head = tail_ff;
                nxt_tail = push_data;
            end
        end else if (push) begin
            nxt_count = count_ff + 2'd1;
            if (count_ff == 2'd0) begin
                nxt_head = push_data;
            end else begin
                nxt_tail = push_data;
            end
        end else if (pop) begin
            nxt_count = count_ff - 2'd1;
            nxt_head = tail_ff;
        end
        nxt_rd_valid = (nxt_count != 2'd0);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= S_POR;
            req_ff <= '0;
            pins_ff <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                         read_strobe_n: 1'b1, wp_n: 1'b0, dq_out: 8'h00, dq_oe: 1'b0};
            resp_ff <= '0;
            cnt_ff <= '0;
            left_ff <= 16'h0000;
            aidx_ff <= 3'd0;
            stat_ff <= 1'b0;
            req_ready_ff <= 1'b0;
            wr_ready_ff <= 1'b0;
            resp_valid_ff <= 1'b0;
            head_ff <= 8'h00;
            tail_ff <= 8'h00;
            count_ff <= 2'd0;
            rd_valid_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            pins_ff <= nxt_pins;
            resp_ff <= nxt_resp;
            cnt_ff <= nxt_cnt;
            left_ff <= nxt_left;
            aidx_ff <= nxt_aidx;
            stat_ff <= nxt_stat;
            req_ready_ff <= nxt_req_ready;
            wr_ready_ff <= nxt_wr_ready;
            resp_valid_ff <= nxt_resp_valid;
            head_ff <= nxt_head;
            tail_ff <= nxt_tail;
            count_ff <= nxt_count;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    assign req_ready = req_ready_ff;
    assign wr_ready = wr_ready_ff;
    assign rd_data = head_ff;
    assign rd_valid = rd_valid_ff;
    assign resp = resp_ff;
    assign resp_valid = resp_valid_ff;
    assign pins = pins_ff;
endmodule

`default_nettype wire

// ===== include/nand_host_pkg.sv
/* Opcodes, timing counts and carriers of the NAND host sequencer.
   Assumes a 250 MHz clock. */
package nand_host_pkg;
    // ==========================================================
    // Opcodes
    localparam logic [7:0] OPC_READ = 8'h00;
    localparam logic [7:0] OPC_READ_GO = 8'h30;
    localparam logic [7:0] OPC_PROG = 8'h80;
    localparam logic [7:0] OPC_PROG_PLANE1 = 8'h81;
    localparam logic [7:0] OPC_PROG_GO = 8'h10;
    localparam logic [7:0] OPC_PROG_NEXT_PLANE = 8'h11;
    localparam logic [7:0] OPC_PROG_CACHE = 8'h15;
    localparam logic [7:0] OPC_ERASE = 8'h60;
    localparam logic [7:0] OPC_ERASE_GO = 8'hd0;
    localparam logic [7:0] OPC_ERASE_NEXT_PLANE = 8'hd1;
    localparam logic [7:0] OPC_RESET = 8'hff;
    localparam logic [7:0] OPC_STATUS = 8'h70;
    localparam logic [7:0] OPC_STATUS_ENH = 8'h78;
    localparam logic [7:0] OPC_PROT_STATUS = 8'h7a;
    localparam logic [7:0] OPC_ID = 8'h90;
    localparam logic [7:0] OPC_PARAM_PAGE = 8'hec;
    localparam logic [7:0] OPC_UNIQUE_ID = 8'hed;
    localparam logic [7:0] OPC_SET_FEAT = 8'hef;
    localparam logic [7:0] OPC_GET_FEAT = 8'hee;
    localparam logic [7:0] BAD_BLOCK_MARK = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_WP_NS = 10;
    localparam int T_WH_NS = 7;
    localparam int T_WC_NS = 20;
    localparam int T_REA_NS = 16;
    localparam int T_REH_NS = 7;
    localparam int T_RC_NS = 20;
    localparam int T_WHR_NS = 60;
    localparam int T_RHW_NS = 60;
    localparam int T_ADL_NS = 70;
    localparam int T_WB_NS = 100;
    localparam int T_POR_US = 1000;
    localparam int T_BUSY_MAX_US = 3500;
    localparam int SYNC_STAGES = 2;

    function automatic int cyc_min(input int ns);
        cyc_min = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction

    localparam int WE_LOW_CYC = cyc_min(T_WP_NS);
    localparam int WE_CYC = (cyc_min(T_WC_NS) > WE_LOW_CYC + cyc_min(T_WH_NS)) ?
        cyc_min(T_WC_NS) : WE_LOW_CYC + cyc_min(T_WH_NS);
    localparam int RE_SAMPLE_CYC = cyc_min(T_REA_NS) + SYNC_STAGES + 1;
    localparam int RE_CYC = (cyc_min(T_RC_NS) > RE_SAMPLE_CYC + cyc_min(T_REH_NS)) ?
        cyc_min(T_RC_NS) : RE_SAMPLE_CYC + cyc_min(T_REH_NS);
    localparam int WHR_CYC = cyc_min(T_WHR_NS);
    localparam int RHW_CYC = cyc_min(T_RHW_NS);
    localparam int ADL_CYC = cyc_min(T_ADL_NS);
    localparam int WB_CYC = cyc_min(T_WB_NS);
    localparam int POR_CYC_DEF = cyc_min(T_POR_US * 1000);
    localparam int BUSY_MAX_CYC_DEF = cyc_min(T_BUSY_MAX_US * 1000);
    localparam int CNT_W = 20;
    localparam int BUF_DEPTH = 2;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] cmd1;
        logic has_cmd2;
        logic [7:0] cmd2;
        logic [2:0] n_addr;
        logic [39:0] addr;
        logic [15:0] n_wdata;
        logic [15:0] n_rdata;
        logic wait_busy;
        logic auto_status;
        logic marker_checked;
    } req_t;

    typedef struct packed {
        logic [7:0] status;
        logic refused;
        logic timeout;
    } resp_t;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
        logic wp_n;
        logic [7:0] dq_out;
        logic dq_oe;
    } pins_t;

    typedef enum logic [3:0] {
        S_POR, S_IDLE, S_WAIT_RDY, S_CMD1, S_ADDR, S_ADL, S_WDATA, S_CMD2,
        S_WB, S_BUSY, S_STAT_CMD, S_WHR, S_RDATA, S_DONE
    } state_t;
endpackage

// ===== verif/nand_host_seq_asserts.sv
/* Checks on the pins and streams of nand_host_seq.
   Bound to it; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module nand_host_seq_asserts
    import nand_host_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire req_t req,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire resp_t resp,
    input wire logic resp_valid,
    input wire logic write_allow,
    input wire pins_t pins,
    input wire logic rb_n_in
);
    logic seen_ready_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seen_ready_ff <= 1'b0;
        end else begin
            seen_ready_ff <= seen_ready_ff | req_ready;
        end
    end
    // ==========================================================
    // Assertions
    chk_cmd_latch: assert property (pins.cle |-> !pins.ale && !pins.ce_n)
        else $error("cle with ale");
    chk_addr_latch: assert property (pins.ale |-> !pins.cle && !pins.ce_n)
        else $error("ale with cle");
    chk_write_sel: assert property (!pins.we_n |-> !pins.ce_n && pins.read_strobe_n)
        else $error("we without ce");
    chk_read_cycle: assert property (!pins.read_strobe_n |->
        !pins.cle && !pins.ale && pins.we_n && !pins.dq_oe)
        else $error("bad read cycle");
    chk_capture_edge: assert property ($rose(pins.we_n) |->
        pins.dq_oe && $stable(pins.dq_out) && $stable({pins.cle, pins.ale}))
        else $error("bus moved at we rise");
    chk_wr_take: assert property (wr_valid && wr_ready |=> !pins.we_n && !wr_ready &&
        pins.dq_out == $past(wr_data) && !pins.cle && !pins.ale)
        else $error("write byte not strobed");
    chk_busy_only: assert property ((!rb_n_in) [*6] ##0 (pins.cle && !pins.we_n) |->
        pins.dq_out inside {OPC_RESET, OPC_STATUS, OPC_STATUS_ENH})
        else $error("busy command");
    chk_por_quiet: assert property (!seen_ready_ff |-> pins.ce_n)
        else $error("early select");
    chk_wp_follow: assert property (req_ready && $past(req_ready) |->
        pins.wp_n == $past(write_allow))
        else $error("wp lag");
    chk_refuse_fast: assert property (req_valid && req_ready && req.cmd1 == OPC_ERASE &&
        !req.marker_checked |=> resp_valid && resp.refused && pins.ce_n)
        else $error("erase not refused");
    chk_ce_quiet: assert property (pins.ce_n |-> pins.we_n && pins.read_strobe_n)
        else $error("strobe while deselected");
    chk_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("read byte lost in stall");
    cover property (resp_valid && resp.refused);
    cover property (rd_valid && !rd_ready);
    cover property (wr_valid && wr_ready);
endmodule
bind nand_host_seq nand_host_seq_asserts u_chk (.*);
`default_nettype wire

// ===== verif/nand_dev_model.sv
/* Strobed NAND device model, one 16-byte page.
   Released bus shows inverted data. */
`timescale 1ns/100ps
`default_nettype none
module nand_dev_model
    import nand_host_pkg::*;
#(
    parameter int POR_NS = 200,
    parameter int OP_NS = 600
) (
    input wire pins_t pins,
    output logic [7:0] dq,
    output logic rb_pull
);
    logic [7:0] page [16];
    logic [7:0] cmd;
    logic [3:0] ptr;
    logic fail;
    int busy_ns;
    initial begin
        foreach (page[i]) page[i] = ERASED_BYTE;
        cmd = OPC_READ;
        ptr = 4'h0;
        fail = 1'b0;
        dq = 8'h5a;
        busy_ns = POR_NS;
    end
    always #1 if (busy_ns > 0) busy_ns = busy_ns - 1;
    assign rb_pull = (busy_ns != 0);
    task automatic command(input logic [7:0] c);
        if (busy_ns != 0 && !(c inside {OPC_RESET, OPC_STATUS, OPC_STATUS_ENH})) return;
        case (c)
            OPC_READ_GO: busy_ns = 200;
            OPC_PROG_GO, OPC_PROG_CACHE, OPC_PROG_NEXT_PLANE, OPC_ERASE_GO,
            OPC_ERASE_NEXT_PLANE: begin
                fail = !pins.wp_n;
                if (pins.wp_n) busy_ns = OP_NS;
                if (pins.wp_n && c == OPC_ERASE_GO) foreach (page[i]) page[i] = ERASED_BYTE;
            end
            OPC_RESET: begin
                busy_ns = 40;
                fail = 1'b0;
            end
            OPC_READ, OPC_PROG, OPC_PROG_PLANE1, OPC_ERASE, OPC_STATUS, OPC_STATUS_ENH,
            OPC_PROT_STATUS, OPC_ID, OPC_PARAM_PAGE, OPC_UNIQUE_ID, OPC_SET_FEAT,
            OPC_GET_FEAT: ;
            default: return;
        endcase
        cmd = c;
        ptr = 4'h0;
    endtask
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.read_strobe_n) begin
            if (pins.cle && !pins.ale) command(pins.dq_out);
            else if (pins.ale && !pins.cle) ptr = 4'h0;
            else if (!pins.cle && !pins.ale && pins.wp_n && busy_ns == 0) begin
                page[ptr] = pins.dq_out;
                ptr = ptr + 4'h1;
            end
        end
    end
    always @(negedge pins.read_strobe_n) begin
        if (!pins.ce_n) begin
            #5;
            if (cmd inside {OPC_STATUS, OPC_STATUS_ENH}) dq = {pins.wp_n, busy_ns == 0, 5'h00, fail};
            else if (cmd inside {OPC_ID, OPC_PARAM_PAGE, OPC_UNIQUE_ID, OPC_SET_FEAT,
                OPC_GET_FEAT, OPC_PROT_STATUS}) dq = cmd;
            else begin
                dq = page[ptr];
                ptr = ptr + 4'h1;
            end
        end
    end
    always @(posedge pins.read_strobe_n) begin
        #6;
        dq = ~dq;
    end
    always @(negedge pins.wp_n) begin
        if (cmd inside {OPC_PROG_GO, OPC_PROG_CACHE, OPC_ERASE_GO}) busy_ns = 0;
    end
endmodule
`default_nettype wire

// ===== verif/nand_host_seq_tb_top.sv
/* Bench: nand_host_seq against nand_dev_model.
   Makes clock and reset. */
`timescale 1ns/100ps
`default_nettype none
module nand_host_seq_tb_top
    import nand_host_pkg::*;
;
    logic clk, rst_b, req_valid, req_ready, wr_valid, wr_ready, rd_valid, rd_ready;
    logic resp_valid, write_allow, rb_pull;
    logic [7:0] wr_data, rd_data, dev_dq;
    logic [7:0] wq[$], rq[$];
    req_t req;
    resp_t resp, rsp;
    pins_t pins;
    int fail_count = 0, tests_run = 0, cycles = 0;

    nand_host_seq #(.POR_CYC(60), .BUSY_MAX_CYC(200)) dut (.clk(clk), .rst_b(rst_b),
        .req(req), .req_valid(req_valid), .req_ready(req_ready), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .resp(resp), .resp_valid(resp_valid), .write_allow(write_allow),
        .pins(pins), .dq_in(pins.dq_oe ? pins.dq_out : dev_dq), .rb_n_in(!rb_pull));
    nand_dev_model u_dev (.pins(pins), .dq(dev_dq), .rb_pull(rb_pull));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic results();
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic req_t mk(input logic [7:0] c1, c2, input logic [2:0] na,
        input logic [15:0] nr, input logic wb, as, mc);
        mk = '0;
        mk.cmd1 = c1;
        mk.has_cmd2 = (c2 != 8'h00);
        mk.cmd2 = c2;
        mk.n_addr = na;
        mk.n_rdata = nr;
        mk.wait_busy = wb;
        mk.auto_status = as;
        mk.marker_checked = mc;
    endfunction
    // One frame: wq out, rq in, rsp back
    task automatic frame(input req_t r, input int stall);
        req_t q;
        bit done = 0, tw;
        q = r;
        q.n_wdata = 16'(wq.size());
        rq = {};
        req <= q;
        req_valid <= 1'b1;
        do @(negedge clk); while (req_ready !== 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
        wr_valid <= (wq.size() != 0);
        if (wq.size() != 0) wr_data <= wq[0];
        while (!done || rq.size() < q.n_rdata) begin
            @(negedge clk);
            if (resp_valid === 1'b1) begin
                done = 1;
                rsp = resp;
            end
            if (rd_valid === 1'b1 && rd_ready) rq.push_back(rd_data);
            tw = (wr_valid && wr_ready === 1'b1);
            @(posedge clk);
            if (tw) begin
                void'(wq.pop_front());
                wr_valid <= (wq.size() != 0);
                if (wq.size() != 0) wr_data <= wq[0];
            end
            rd_ready <= (stall <= 0);
            stall--;
        end
        repeat (20) @(posedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset_ids();
        logic [7:0] ops [6] = '{OPC_ID, OPC_PARAM_PAGE, OPC_UNIQUE_ID, OPC_SET_FEAT,
            OPC_GET_FEAT, OPC_PROT_STATUS};
        frame(mk(OPC_RESET, 8'h00, 3'd0, 16'd0, 1'b1, 1'b0, 1'b0), 0);
        chk("reset timeout", 8'h00, {7'h00, rsp.timeout});
        foreach (ops[i]) begin
            frame(mk(ops[i], 8'h00, 3'd1, 16'd1, 1'b0, 1'b0, 1'b0), 0);
            chk("query byte", ops[i], rq[0]);
        end
    endtask
    task automatic t_prog_read();
        wq = '{8'ha1, 8'ha2, 8'ha3, 8'ha4};
        frame(mk(OPC_PROG, OPC_PROG_GO, 3'd2, 16'd0, 1'b1, 1'b1, 1'b0), 0);
        chk("program status", 8'hc0, rsp.status);
        frame(mk(OPC_READ, OPC_READ_GO, 3'd2, 16'd4, 1'b1, 1'b0, 1'b0), 110);
        for (int i = 0; i < 4; i++) chk("page byte", 8'ha1 + 8'(i), rq[i]);
        write_allow <= 1'b0;
        repeat (30) @(posedge clk);
        wq = '{8'h5b};
        frame(mk(OPC_PROG, OPC_PROG_GO, 3'd2, 16'd0, 1'b1, 1'b1, 1'b0), 0);
        chk("inhibit status", 8'h41, rsp.status);
        frame(mk(OPC_READ, OPC_READ_GO, 3'd2, 16'd1, 1'b1, 1'b0, 1'b0), 0);
        chk("kept byte", 8'ha1, rq[0]);
        write_allow <= 1'b1;
        repeat (30) @(posedge clk);
    endtask
    task automatic t_erase();
        frame(mk(OPC_ERASE, OPC_ERASE_GO, 3'd3, 16'd0, 1'b1, 1'b1, 1'b0), 0);
        chk("refused flag", 8'h01, {7'h00, rsp.refused});
        frame(mk(OPC_ERASE, OPC_ERASE_GO, 3'd3, 16'd0, 1'b0, 1'b0, 1'b1), 0);
        frame(mk(OPC_STATUS, 8'h00, 3'd0, 16'd1, 1'b0, 1'b0, 1'b0), 0);
        chk("busy status", 8'h80, rq[0]);
        frame(mk(OPC_READ, OPC_READ_GO, 3'd2, 16'd1, 1'b1, 1'b0, 1'b0), 0);
        chk("erased byte", ERASED_BYTE, rq[0]);
    endtask
    task automatic t_two_plane();
        for (int i = 0; i < 2; i++) begin
            wq = '{8'h11};
            frame(mk(OPC_PROG, OPC_PROG_NEXT_PLANE, 3'd2, 16'd0, 1'b1, 1'b0, 1'b0), 0);
            wq = '{8'h22};
            frame(mk(i ? OPC_PROG_PLANE1 : OPC_PROG, i ? OPC_PROG_CACHE : OPC_PROG_GO, 3'd2,
                16'd0, 1'b1, 1'b1, 1'b0), 0);
            chk("plane status", 8'hc0, rsp.status);
        end
        frame(mk(OPC_ERASE, OPC_ERASE_NEXT_PLANE, 3'd3, 16'd0, 1'b1, 1'b0, 1'b1), 0);
        frame(mk(OPC_ERASE, OPC_ERASE_GO, 3'd3, 16'd0, 1'b1, 1'b1, 1'b1), 0);
        chk("plane erase", 8'hc0, rsp.status);
        frame(mk(OPC_ERASE, 8'h00, 3'd3, 16'd0, 1'b0, 1'b0, 1'b1), 0);
        frame(mk(OPC_ERASE, OPC_ERASE_GO, 3'd3, 16'd0, 1'b1, 1'b1, 1'b1), 0);
        chk("legacy erase", 8'hc0, rsp.status);
    endtask
    initial begin
        rst_b = 1'b0;
        req = '0;
        req_valid = 1'b0;
        wr_data = 8'h00;
        wr_valid = 1'b0;
        rd_ready = 1'b1;
        write_allow = 1'b1;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_ids();
        t_prog_read();
        t_erase();
        t_two_plane();
        results();
    end
endmodule
`default_nettype wire
